// File: core/tcc_timer.sv
// Top of the 16-bit capture/compare timer with four general registers
// Notes on behaviour
// - Standby stops counting; system-clock sources also stop in subactive and subsleep.
// - Sub-clock and external sources keep counting in subactive and subsleep too.
// - No counting during oscillation stabilisation, whatever the source.
// - Counter clear in the write cycle beats the software write.
// - Software write to the counter beats a simultaneous increment.
// - Internal source switch from low to high counts as one rising edge.
// - Capture edge sets its flag even with counting disabled; interrupt if enabled.
// - Capture meeting a write to same register: written value kept, flag set.
// - Read during capture returns old value; new value readable next clock.
// - Buffered capture meeting a buffer write: buffer keeps written value.
// - Compare match meeting a register write: written value kept, pin changes.
// - Buffered compare meeting write to A or B: no transfer, pin changes.
// - Buffered compare meeting buffer write: A or B gets old buffer value.
// - Buffer registers C or D still drive their pins on own match.
// - Count may slip one step when entering subactive on slow sources.
// - Compare match fires when the counter leaves the matching value.
// - Flag clears only after read as one then written with zero.
// - Buffered capture moves old A into buffer, then counter into A.
`timescale 1ns/1ps
module tcc_timer (
	input  wire logic        clk,                      // System clock, 40 MHz
	input  wire logic        reset,                    // Asynchronous reset, active high
	input  wire logic        wb_cyc_i,                 // Wishbone cycle
	input  wire logic        wb_stb_i,                 // Wishbone strobe
	input  wire logic        wb_we_i,                  // Wishbone write enable
	input  wire logic [7:0]  wb_adr_i,                 // Wishbone byte address
	input  wire logic [31:0] wb_dat_i,                 // Wishbone write data
	input  wire logic [3:0]  wb_sel_i,                 // Wishbone byte lanes
	output logic      [31:0] wb_dat_o,                 // Wishbone read data
	output logic             wb_ack_o,                 // Wishbone acknowledge
	input  wire logic [2:0]  power_mode,               // Chip power mode
	input  wire logic        osc_stab,                 // Oscillator stabilisation interval
	input  wire logic        sub_clk,                  // Sub-clock, sampled as a pin
	input  wire logic        external_count_clock_pin, // External count clock
	input  wire logic [3:0]  capture_compare_pin_in,   // Pins a..d, input level
	output logic      [3:0]  capture_compare_pin_out,  // Pins a..d, output level
	output logic      [3:0]  capture_compare_pin_oe,   // Pins a..d, driven when high
	output logic             irq                       // Interrupt request
);
	// ==========================================================
	// Helpers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [15:0] v;
		v = old;
		if (sel[0]) begin
			v[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			v[15:8] = dat[15:8];
		end
		return v;
	endfunction

	function automatic logic [7:0] gr_ofs(input int unsigned i);
		return tcc_pkg::OFS_GRA + 8'(i) * tcc_pkg::OFS_STRIDE;
	endfunction

	function automatic logic is_internal(input logic [2:0] src);
		return src <= tcc_pkg::SRC_PHI8;
	endfunction

	// ==========================================================
	// Bus front end and pin synchronisers
	tcc_pkg::tcc_req_t               req;
	logic [31:0]                     rdata;
	logic [tcc_pkg::SYNC_W-1:0]      lvl;

	tcc_wb_slave u_bus (
		.clk      (clk),
		.reset    (reset),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_dat_i (wb_dat_i),
		.wb_sel_i (wb_sel_i),
		.rdata    (rdata),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.req      (req)
	);

	// Pulses shorter than two system clocks may be lost here
	tcc_sync #(.W(tcc_pkg::SYNC_W)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({sub_clk, external_count_clock_pin, capture_compare_pin_in}),
		.q     (lvl)
	);

	// ==========================================================
	// State and per-cycle decisions
	tcc_pkg::tcc_state_t r;
	tcc_pkg::tcc_state_t n;
	logic [2:0]          src;
	logic                sel_lvl;
	logic                tick_raw;
	logic                mode_ok;
	logic                tick;
	logic                clr;
	logic                wr_cnt;
	logic [3:0]          wr_gr;
	logic [3:0]          cmp_mode;
	logic [3:0]          cm;
	logic [3:0]          cap;
	logic [3:0]          rise;
	logic [3:0]          fall;
	logic [3:0]          clr_mask;
	logic [1:0]          act;
	logic [1:0]          bufm;

	always_comb begin
		n = r;
		src = r.ctrl[tcc_pkg::CTRL_SRC +: 3];
		bufm = {r.ctrl[tcc_pkg::CTRL_BUF_B], r.ctrl[tcc_pkg::CTRL_BUF_A]};
		n.presc = r.presc + 3'h1;
		n.sub_prev = lvl[tcc_pkg::SYNC_SUB];
		if (lvl[tcc_pkg::SYNC_SUB] && !r.sub_prev) begin
			n.sub_presc = r.sub_presc + 4'h1;
		end

		// Source level; a switch that lands high is seen as an edge
		tick_raw = 1'b0;
		case (src)
			tcc_pkg::SRC_PHI1:   sel_lvl = 1'b1;
			tcc_pkg::SRC_PHI2:   sel_lvl = r.presc[tcc_pkg::PRE_DIV2];
			tcc_pkg::SRC_PHI4:   sel_lvl = r.presc[tcc_pkg::PRE_DIV4];
			tcc_pkg::SRC_PHI8:   sel_lvl = r.presc[tcc_pkg::PRE_DIV8];
			tcc_pkg::SRC_SUB1:   sel_lvl = lvl[tcc_pkg::SYNC_SUB];
			tcc_pkg::SRC_SUB4:   sel_lvl = r.sub_presc[tcc_pkg::SUB_DIV4];
			tcc_pkg::SRC_SUB16:  sel_lvl = r.sub_presc[tcc_pkg::SUB_DIV16];
			default:             sel_lvl = lvl[tcc_pkg::SYNC_EXT];
		endcase
		n.sel_prev = sel_lvl;
		if (src == tcc_pkg::SRC_PHI1) begin
			tick_raw = 1'b1;
		end else begin
			tick_raw = sel_lvl & ~r.sel_prev;
		end

		// Power gating: standby never counts, slow sources run in sub modes
		case (power_mode)
			tcc_pkg::PM_ACTIVE:  mode_ok = 1'b1;
			tcc_pkg::PM_SLEEP:   mode_ok = 1'b1;
			tcc_pkg::PM_SUBACT:  mode_ok = ~is_internal(src);
			tcc_pkg::PM_SUBSLP:  mode_ok = ~is_internal(src);
			default:             mode_ok = 1'b0;
		endcase
		// Stabilisation only holds the count, it never clears it
		tick = tick_raw & r.ctrl[tcc_pkg::CTRL_EN] & mode_ok & ~osc_stab;

		// Match is taken when the counter steps off the matching value
		for (int i = 0; i < 4; i++) begin
			cmp_mode[i] = ~r.ioc[i * tcc_pkg::IOC_NIB + tcc_pkg::IOC_CAPT];
			cm[i] = tick & cmp_mode[i] & (r.counter == r.gr[i]);
		end

		// Capture edges work even while counting is disabled
		n.pin_prev = lvl[3:0];
		rise = lvl[3:0] & ~r.pin_prev;
		fall = ~lvl[3:0] & r.pin_prev;
		for (int i = 0; i < 4; i++) begin
			act = r.ioc[i * tcc_pkg::IOC_NIB + tcc_pkg::IOC_ACT +: 2];
			cap[i] = ~cmp_mode[i] & ((act[tcc_pkg::EDGE_RISE] & rise[i]) | (act[tcc_pkg::EDGE_FALL] & fall[i]));
		end
		// A buffer register does not capture on its own pin
		cap[2] = cap[2] & ~bufm[0];
		cap[3] = cap[3] & ~bufm[1];

		// Counter: clear beats write, write beats increment
		wr_cnt = req.wr & (req.adr == tcc_pkg::OFS_COUNT);
		clr = cm[0] & r.ctrl[tcc_pkg::CTRL_CLR_A];
		if (clr) begin
			n.counter = '0;
		end else if (wr_cnt) begin
			n.counter = merge16(r.counter, req.dat, req.sel);
		end else if (tick) begin
			n.counter = r.counter + 16'h0001;
		end

		// General registers: events first, then buffer moves, writes last
		for (int i = 0; i < 4; i++) begin
			wr_gr[i] = req.wr & (req.adr == gr_ofs(i));
			if (cap[i]) begin
				n.gr[i] = r.counter;
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (bufm[i] && cap[i]) begin
				n.gr[i + 2] = r.gr[i];
			end
			if (bufm[i] && cm[i]) begin
				n.gr[i] = r.gr[i + 2]; // Old buffer value
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (wr_gr[i]) begin
				n.gr[i] = merge16(r.gr[i], req.dat, req.sel);
			end
		end

		// Compare outputs change even when the register is being written
		for (int i = 0; i < 4; i++) begin
			act = r.ioc[i * tcc_pkg::IOC_NIB + tcc_pkg::IOC_ACT +: 2];
			n.pin_oe[i] = cmp_mode[i];
			if (cm[i]) begin
				case (act)
					tcc_pkg::ACT_LOW:  n.pin_out[i] = 1'b0;
					tcc_pkg::ACT_HIGH: n.pin_out[i] = 1'b1;
					tcc_pkg::ACT_TOG:  n.pin_out[i] = ~r.pin_out[i];
					default:           n.pin_out[i] = r.pin_out[i];
				endcase
			end
		end

		// Flags: read arms, zero write clears an armed bit, a new event wins
		clr_mask = '0;
		if (req.rd && req.adr == tcc_pkg::OFS_STATUS) begin
			n.armed = r.flags;
		end
		if (req.wr && req.adr == tcc_pkg::OFS_STATUS && req.sel[0]) begin
			clr_mask = r.armed & ~req.dat[3:0];
			n.armed = '0;
		end
		n.flags = (r.flags & ~clr_mask) | cm | cap;

		// Plain control registers
		if (req.wr && req.adr == tcc_pkg::OFS_CTRL) begin
			n.ctrl = merge16(r.ctrl, req.dat, req.sel);
		end
		if (req.wr && req.adr == tcc_pkg::OFS_IOCTL) begin
			n.ioc = merge16(r.ioc, req.dat, req.sel);
		end
		if (req.wr && req.adr == tcc_pkg::OFS_IRQEN && req.sel[0]) begin
			n.irq_en = req.dat[3:0];
		end
		n.irq = |(n.flags & n.irq_en);

		// Read mux sees the values before this cycle's updates
		case (req.adr)
			tcc_pkg::OFS_CTRL:   rdata = {16'h0000, r.ctrl};
			tcc_pkg::OFS_IOCTL:  rdata = {16'h0000, r.ioc};
			tcc_pkg::OFS_STATUS: rdata = {28'h0000000, r.flags};
			tcc_pkg::OFS_IRQEN:  rdata = {28'h0000000, r.irq_en};
			tcc_pkg::OFS_COUNT:  rdata = {16'h0000, r.counter};
			gr_ofs(0):           rdata = {16'h0000, r.gr[0]};
			gr_ofs(1):           rdata = {16'h0000, r.gr[1]};
			gr_ofs(2):           rdata = {16'h0000, r.gr[2]};
			gr_ofs(3):           rdata = {16'h0000, r.gr[3]};
			default:             rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r <= tcc_pkg::ST_RST;
		end else begin
			r <= n;
		end
	end

	assign capture_compare_pin_out = r.pin_out;
	assign capture_compare_pin_oe = r.pin_oe;
	assign irq = r.irq;

	// ==========================================================
	// Checks
	standby_hold_a: assert property (@(posedge clk) disable iff (reset)
		(power_mode == tcc_pkg::PM_STANDBY) && !wr_cnt |=> r.counter == $past(r.counter))
		else $error("counter moved in standby");

	sub_count_a: assert property (@(posedge clk) disable iff (reset)
		(power_mode == tcc_pkg::PM_SUBACT) && !is_internal(src) && tick_raw && !osc_stab
		&& r.ctrl[tcc_pkg::CTRL_EN] && !wr_cnt && !clr |=> r.counter == $past(r.counter) + 16'h0001)
		else $error("slow source did not count in subactive");

	osc_hold_a: assert property (@(posedge clk) disable iff (reset)
		osc_stab && !wr_cnt && !clr |=> r.counter == $past(r.counter))
		else $error("counter moved during stabilisation");

	clear_wins_a: assert property (@(posedge clk) disable iff (reset)
		cm[0] && r.ctrl[tcc_pkg::CTRL_CLR_A] && wr_cnt |=> r.counter == 16'h0000)
		else $error("write beat a counter clear");

	write_wins_a: assert property (@(posedge clk) disable iff (reset)
		wr_cnt && tick && !clr && (req.sel[1:0] == 2'h3) |=> r.counter == $past(req.dat[15:0]))
		else $error("increment beat a counter write");

	capt_flag_a: assert property (@(posedge clk) disable iff (reset)
		cap[0] |=> r.flags[0] && (r.irq || !r.irq_en[0]))
		else $error("capture did not set its flag");

	capt_write_a: assert property (@(posedge clk) disable iff (reset)
		cap[1] && wr_gr[1] && (req.sel[1:0] == 2'h3) |=> r.gr[1] == $past(req.dat[15:0]) && r.flags[1])
		else $error("capture overrode a register write");

	read_old_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && (req.adr == tcc_pkg::OFS_GRA) && cap[0] |=> wb_dat_o[15:0] == $past(r.gr[0]))
		else $error("read during capture did not return old value");

	cmp_toggle_a: assert property (@(posedge clk) disable iff (reset)
		cm[2] && (r.ioc[2 * tcc_pkg::IOC_NIB + tcc_pkg::IOC_ACT +: 2] == tcc_pkg::ACT_TOG)
		|=> capture_compare_pin_out[2] != $past(capture_compare_pin_out[2]))
		else $error("compare match did not toggle the pin");

	buf_move_a: assert property (@(posedge clk) disable iff (reset)
		bufm[0] && cm[0] && !wr_gr[0] |=> r.gr[0] == $past(r.gr[2]))
		else $error("buffered compare did not move the old buffer value");

	flag_keep_a: assert property (@(posedge clk) disable iff (reset)
		r.flags[3] && !r.armed[3] |=> r.flags[3])
		else $error("flag cleared without an arming read");
endmodule

// File: core/tcc_pkg.sv
// Shared constants, register map and carrier types of the capture/compare timer
package tcc_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_IOCTL  = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQEN  = 8'h0C;
	localparam logic [7:0] OFS_COUNT  = 8'h10;
	localparam logic [7:0] OFS_GRA    = 8'h14;
	localparam logic [7:0] OFS_STRIDE = 8'h04;

	// ==========================================================
	// Control register fields
	localparam int unsigned CTRL_EN    = 0;
	localparam int unsigned CTRL_SRC   = 1;
	localparam int unsigned CTRL_CLR_A = 4;
	localparam int unsigned CTRL_BUF_A = 5;
	localparam int unsigned CTRL_BUF_B = 6;

	// Per-channel nibble of the I/O control register
	localparam int unsigned IOC_NIB  = 4;
	localparam int unsigned IOC_CAPT = 0;
	localparam int unsigned IOC_ACT  = 1;

	// Compare action / capture edge codes (two bits)
	localparam logic [1:0] ACT_LOW  = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOG  = 2'h3;
	localparam int unsigned EDGE_RISE = 0;
	localparam int unsigned EDGE_FALL = 1;

	// ==========================================================
	// Count sources and power modes
	typedef enum logic [2:0] {
		SRC_PHI1   = 3'h0,
		SRC_PHI2   = 3'h1,
		SRC_PHI4   = 3'h2,
		SRC_PHI8   = 3'h3,
		SRC_SUB1   = 3'h4,
		SRC_SUB4   = 3'h5,
		SRC_SUB16  = 3'h6,
		SRC_EXTPIN = 3'h7
	} tcc_src_t;

	typedef enum logic [2:0] {
		PM_ACTIVE  = 3'h0,
		PM_SLEEP   = 3'h1,
		PM_SUBSLP  = 3'h3,
		PM_SUBACT  = 3'h2,
		PM_STANDBY = 3'h6
	} tcc_pmode_t;

	// Synchronised pin positions
	localparam int unsigned SYNC_W   = 6;
	localparam int unsigned SYNC_EXT = 4;
	localparam int unsigned SYNC_SUB = 5;

	// Prescaler taps
	localparam int unsigned PRE_DIV2  = 0;
	localparam int unsigned PRE_DIV4  = 1;
	localparam int unsigned PRE_DIV8  = 2;
	localparam int unsigned SUB_DIV4  = 1;
	localparam int unsigned SUB_DIV16 = 3;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [3:0]  sel;
	} tcc_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} tcc_wbs_t;

	typedef struct packed {
		logic [15:0]      ctrl;
		logic [15:0]      ioc;
		logic [3:0]       flags;
		logic [3:0]       armed;
		logic [3:0]       irq_en;
		logic [15:0]      counter;
		logic [3:0][15:0] gr;
		logic [3:0]       pin_out;
		logic [3:0]       pin_oe;
		logic [2:0]       presc;
		logic [3:0]       sub_presc;
		logic             sub_prev;
		logic             sel_prev;
		logic [3:0]       pin_prev;
		logic             irq;
	} tcc_state_t;

	localparam tcc_state_t ST_RST = '0;
	localparam tcc_wbs_t   WBS_RST = '0;

endpackage

// File: core/tcc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tcc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,   // System clock
	input  wire logic         reset, // Asynchronous reset, active high
	input  wire logic [W-1:0] d,     // Raw asynchronous inputs
	output logic      [W-1:0] q      // Filtered levels
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} tcc_sync_st_t;

	tcc_sync_st_t r;
	tcc_sync_st_t n;

	// A level only moves once stages two and three agree
	always_comb begin
		n = r;
		n.s1 = d;
		n.s2 = r.s1;
		n.s3 = r.s2;
		for (int i = 0; i < W; i++) begin
			if (r.s2[i] == r.s3[i]) begin
				n.lvl[i] = r.s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign q = r.lvl;
endmodule

// File: core/tcc_wb_slave.sv
// Classic Wishbone slave front end: one access strobe, registered ack and data
`timescale 1ns/1ps
module tcc_wb_slave (
	input  wire logic             clk,      // System clock
	input  wire logic             reset,    // Asynchronous reset, active high
	input  wire logic             wb_cyc_i, // Bus cycle
	input  wire logic             wb_stb_i, // Strobe
	input  wire logic             wb_we_i,  // Write enable
	input  wire logic [7:0]       wb_adr_i, // Byte address
	input  wire logic [31:0]      wb_dat_i, // Write data
	input  wire logic [3:0]       wb_sel_i, // Byte lanes
	input  wire logic [31:0]      rdata,    // Read data of the addressed register
	output logic      [31:0]      wb_dat_o, // Registered read data
	output logic                  wb_ack_o, // Registered acknowledge
	output tcc_pkg::tcc_req_t     req       // One-cycle access to the core
);
	tcc_pkg::tcc_wbs_t r;
	tcc_pkg::tcc_wbs_t n;
	logic              go;

	// Access is taken once; ack high blocks a second take of the same request
	always_comb begin
		go = wb_cyc_i & wb_stb_i & ~r.ack;
		n.ack = go;
		n.dat = go && !wb_we_i ? rdata : r.dat;
		req.wr = go & wb_we_i;
		req.rd = go & ~wb_we_i;
		req.adr = wb_adr_i;
		req.dat = wb_dat_i;
		req.sel = wb_sel_i;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r <= tcc_pkg::WBS_RST;
		end else begin
			r <= n;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
endmodule

// File: test/tcc_pin_model.sv
// Pin-side partner: external count clock, capture pulses and a free sub-clock
`timescale 1ns/1ps
module tcc_pin_model (
	input  wire logic       clk,     // System clock
	input  wire logic       reset,   // Asynchronous reset, active high
	input  wire logic [4:0] go,      // Start a pulse: bit 4 count pin, bits 3:0 capture pins
	output logic            ext_pin, // External count clock
	output logic      [3:0] cap_pin, // Capture pin levels
	output logic            sub_clk  // Slow sub-clock, runs free
);
	// ==========================================
	// Pulse sequencer
	logic [2:0] cnt;
	logic [4:0] act;
	logic [3:0] sdiv;

	// High four system clocks, then low at least three, so no pulse is lost
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt  <= 3'h0;
			act  <= 5'h00;
			sdiv <= 4'h0;
		end else begin
			sdiv <= sdiv + 4'h1;
			if (cnt != 3'h0) begin
				cnt <= cnt + 3'h1;
			end else if (go != 5'h00) begin
				act <= go;
				cnt <= 3'h1;
			end
		end
	end
	assign {ext_pin, cap_pin} = (cnt != 3'h0 && cnt <= 3'h4) ? act : 5'h00;
	assign sub_clk = sdiv[3];
endmodule

// File: test/tcc_timer_test.sv
// Self-checking bench of the capture/compare timer
`timescale 1ns/1ps
module tcc_timer_test;
	// ==========================================
	// Signals
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [2:0]  power_mode = 3'h0;
	logic        osc_stab = 1'b0;
	logic [4:0]  go = 5'h00;
	logic        sub_clk;
	logic        ext_pin;
	logic [3:0]  cap_pin;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	logic        irq;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [31:0] q;

	always #12.5 clk = ~clk;

	tcc_timer uut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.power_mode(power_mode), .osc_stab(osc_stab), .sub_clk(sub_clk), .external_count_clock_pin(ext_pin),
		.capture_compare_pin_in(cap_pin), .capture_compare_pin_out(pin_out),
		.capture_compare_pin_oe(pin_oe), .irq(irq));

	tcc_pin_model pins (.clk(clk), .reset(reset), .go(go), .ext_pin(ext_pin), .cap_pin(cap_pin),
		.sub_clk(sub_clk));

	// ==========================================
	// Helpers
	task automatic wrap_up;
		$display("checked %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; waits for ack with no assumed latency
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n == 50) fail_count++;
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	// Pulse spacing leaves room for the pin synchroniser
	task automatic pulse(input logic [4:0] m, input int n);
		repeat (n) begin
			go <= m;
			@(posedge clk);
			go <= 5'h00;
			repeat (14) @(posedge clk);
		end
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		check({28'h0, pin_oe}, 32'h0000000F);
		rdchk(tcc_pkg::OFS_CTRL, 32'h0);
		rdchk(tcc_pkg::OFS_COUNT, 32'h0);
		wr(8'h40, 32'hFFFF);
		rdchk(8'h40, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_modes;
		wr(tcc_pkg::OFS_COUNT, 32'h0);
		wr(tcc_pkg::OFS_CTRL, 32'h0000000F);
		power_mode <= tcc_pkg::PM_SUBACT;
		pulse(5'h10, 3);
		rdchk(tcc_pkg::OFS_COUNT, 32'h3);
		check({31'h0, irq}, 32'h0); // Requests stay disabled before standby
		power_mode <= tcc_pkg::PM_STANDBY;
		pulse(5'h10, 2);
		rdchk(tcc_pkg::OFS_COUNT, 32'h3);
		power_mode <= tcc_pkg::PM_ACTIVE;
		osc_stab <= 1'b1;
		pulse(5'h10, 2);
		rdchk(tcc_pkg::OFS_COUNT, 32'h3);
		osc_stab <= 1'b0;
		pulse(5'h10, 1);
		rdchk(tcc_pkg::OFS_COUNT, 32'h4);
		wr(tcc_pkg::OFS_CTRL, 32'h00000001);
		power_mode <= tcc_pkg::PM_SUBSLP;
		wb(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
		repeat (20) @(posedge clk);
		rdchk(tcc_pkg::OFS_COUNT, q);
		power_mode <= tcc_pkg::PM_ACTIVE;
		$display("t_modes done");
	endtask

	task automatic t_write_race;
		wr(tcc_pkg::OFS_COUNT, 32'h1234);
		wb(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
		check(q, 32'h00001236);
		wr(tcc_pkg::OFS_CTRL, 32'h0);
		$display("t_write_race done");
	endtask

	// Counting stopped, so the captured value is exactly the held count
	task automatic t_capture;
		// Earlier matches on zero registers left flags set; arm and clear them first
		wb(1'b0, tcc_pkg::OFS_STATUS, 32'h0);
		wr(tcc_pkg::OFS_STATUS, 32'h0);
		wr(tcc_pkg::OFS_COUNT, 32'h00A5);
		wr(tcc_pkg::OFS_IOCTL, 32'h3);
		wr(tcc_pkg::OFS_IRQEN, 32'h1);
		check({31'h0, irq}, 32'h0);
		pulse(5'h01, 1);
		check({31'h0, irq}, 32'h1);
		rdchk(tcc_pkg::OFS_GRA, 32'h00A5);
		wr(tcc_pkg::OFS_STATUS, 32'h0);
		rdchk(tcc_pkg::OFS_STATUS, 32'h1);
		wr(tcc_pkg::OFS_STATUS, 32'h0);
		rdchk(tcc_pkg::OFS_STATUS, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("t_capture done");
	endtask

	task automatic t_compare;
		wr(tcc_pkg::OFS_IOCTL, 32'h60);
		wr(tcc_pkg::OFS_COUNT, 32'h0);
		wr(tcc_pkg::OFS_GRA + tcc_pkg::OFS_STRIDE, 32'h0010);
		wr(tcc_pkg::OFS_CTRL, 32'h00000007);
		repeat (100) @(posedge clk);
		check({31'h0, pin_out[1]}, 32'h0);
		repeat (60) @(posedge clk);
		check({31'h0, pin_out[1]}, 32'h1);
		// C and D hold zero in compare mode, so they match as the count leaves zero
		rdchk(tcc_pkg::OFS_STATUS, 32'hE);
		wr(tcc_pkg::OFS_CTRL, 32'h0);
		$display("t_compare done");
	endtask

	// Periodic count cleared by match A, with C buffering A
	task automatic t_buffer;
		wr(tcc_pkg::OFS_GRA, 32'h0007);
		wr(8'h1C, 32'h0003);
		wr(tcc_pkg::OFS_COUNT, 32'h0);
		wr(tcc_pkg::OFS_CTRL, 32'h00000031);
		repeat (20) @(posedge clk);
		wr(tcc_pkg::OFS_CTRL, 32'h0);
		rdchk(tcc_pkg::OFS_GRA, 32'h0003);
		rdchk(8'h1C, 32'h0003);
		rdchk(tcc_pkg::OFS_COUNT, 32'h0003);
		$display("t_buffer done");
	endtask

	// ==========================================
	// Sequence and watchdog
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			wrap_up;
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		t_reset;
		t_modes;
		wr(tcc_pkg::OFS_CTRL, 32'h00000001);
		t_write_race;
		t_capture;
		t_compare;
		t_buffer;
		wrap_up;
	end
endmodule
